// ### core/buck_alt_pkg.sv
// constants for the alternate buck setting register bank
// assumes an 8-bit register port and five converters in a fixed order

package buck_alt_pkg;

  // ****************************************************
  // bus and field geometry
  // ****************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 7;
  localparam int MV_W = 12;
  localparam int NUM_CONV = 5;
  localparam int SLEEP_BIT = 7;
  localparam int CODE_MSB = 6;
  localparam int CODE_LSB = 0;

  // ****************************************************
  // register offsets, index 0 first core ... 4 io
  // ****************************************************
  localparam logic [7:0] CORE_ONE_ALT_OFFSET = 8'hB4;
  localparam logic [7:0] CORE_TWO_ALT_OFFSET = 8'hB5;
  localparam logic [7:0] PROCESSOR_ALT_OFFSET = 8'hB6;
  localparam logic [7:0] MEMORY_ALT_OFFSET = 8'hB7;
  localparam logic [7:0] IO_ALT_OFFSET = 8'hB8;
  localparam logic [4:0][7:0] CONV_OFFSET = {IO_ALT_OFFSET, MEMORY_ALT_OFFSET,
    PROCESSOR_ALT_OFFSET, CORE_TWO_ALT_OFFSET, CORE_ONE_ALT_OFFSET};
  localparam logic [7:0] ALT_STATUS_OFFSET = 8'hF0;
  localparam int STATUS_SEL_BIT = 0;
  localparam int STATUS_WRITTEN_LSB = 1;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] ALT_SETTING_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

  // ****************************************************
  // voltage scales in millivolts
  // ****************************************************
  // 300 mV, 530 mV and 800 mV bases; 10 mV and 20 mV steps
  localparam logic [11:0] CORE_BASE_MV = 12'h12C;
  localparam logic [11:0] PROCESSOR_BASE_MV = 12'h212;
  localparam logic [11:0] WIDE_BASE_MV = 12'h320;
  localparam logic [11:0] FINE_STEP_MV = 12'h00A;
  localparam logic [11:0] WIDE_STEP_MV = 12'h014;
  localparam logic [4:0][11:0] CONV_BASE_MV = {WIDE_BASE_MV, WIDE_BASE_MV,
    PROCESSOR_BASE_MV, CORE_BASE_MV, CORE_BASE_MV};
  localparam logic [4:0][11:0] CONV_STEP_MV = {WIDE_STEP_MV, WIDE_STEP_MV,
    FINE_STEP_MV, FINE_STEP_MV, FINE_STEP_MV};

  // ****************************************************
  // converter operating mode under the alternate set
  // ****************************************************
  typedef enum logic {
    MODE_SYNC = 1'b0,
    MODE_SLEEP = 1'b1
  } buck_mode_t;

endpackage

// ### core/alt_setting_reg.sv
// one 8-bit read/write alternate setting register
// assumes the write enable is already decoded and qualified by the clock enable

`timescale 1ns/1ps

module alt_setting_reg #(
  parameter logic [7:0] RESET_VALUE = buck_alt_pkg::ALT_SETTING_RESET
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  output logic [7:0] value
);

  typedef struct packed {
    logic [7:0] value;
  } reg_state_t;

  reg_state_t state_ff;
  reg_state_t nxt_state;

  // all eight bits store the last write, reads have no side effect
  always_comb begin
    nxt_state = state_ff;
    if (wr_en) begin
      nxt_state.value = wdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '{value: RESET_VALUE};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign value = state_ff.value;

endmodule // alt_setting_reg

// ### core/alt_voltage_scale.sv
// linear map from a 7-bit voltage code to a target in millivolts
// assumes base plus full-scale step count fits in the output width

`timescale 1ns/1ps

module alt_voltage_scale #(
  parameter logic [11:0] BASE_MV = buck_alt_pkg::CORE_BASE_MV,
  parameter logic [11:0] STEP_MV = buck_alt_pkg::FINE_STEP_MV
) (
  input wire logic [6:0] code,
  output logic [11:0] millivolts
);

  logic [11:0] wide_code;
  logic [11:0] offset_mv;

  assign wide_code = {5'h00, code};
  assign offset_mv = 12'(wide_code * STEP_MV);
  assign millivolts = 12'(BASE_MV + offset_mv);

endmodule // alt_voltage_scale

// ### core/buck_alt_voltage_regs.sv
// alternate (B) setting register bank for five buck converters
// assumes a single-cycle register port on clock; alt_select_pin comes from
// the A/B selection pin outside this clock domain
//
// Behaviour
// - first core bit 7: 0 synchronous, 1 sleep while alternate set selected
// - first core code: 0.30 V at zero, plus 10 mV per step, 1.57 V top
// - second core bit 7: 0 synchronous, 1 sleep under alternate set
// - second core code uses the first core scale, 300 mV base, 10 mV step
// - processor bit 7 set gives sleep, cleared synchronous, under alternate set
// - processor code: 0.53 V at zero, 10 mV per step, 1.80 V top
// - memory bit 7: 0 synchronous, 1 sleep while alternate set applies
// - memory code: 0.80 V at zero, 20 mV per step, 3.34 V top
// - io bit 7: 0 synchronous, 1 sleep while alternate set selected
// - io code uses the memory scale, 800 mV base, 20 mV step

`timescale 1ns/1ps

module buck_alt_voltage_regs #(
  parameter int NUM_CONV = buck_alt_pkg::NUM_CONV
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // alternate set selection from the pin
  input wire logic alt_select_pin,
  output logic alt_selected,
  // first core converter
  output logic first_core_alt_sleep_active,
  output logic [6:0] first_core_alt_voltage_code,
  output logic [11:0] first_core_alt_target_mv,
  // second core converter
  output logic second_core_alt_sleep_active,
  output logic [6:0] second_core_alt_voltage_code,
  output logic [11:0] second_core_alt_target_mv,
  // processor converter
  output logic processor_alt_sleep_active,
  output logic [6:0] processor_alt_voltage_code,
  output logic [11:0] processor_alt_target_mv,
  // memory converter
  output logic memory_alt_sleep_active,
  output logic [6:0] memory_alt_voltage_code,
  output logic [11:0] memory_alt_target_mv,
  // io converter
  output logic io_alt_sleep_active,
  output logic [6:0] io_alt_voltage_code,
  output logic [11:0] io_alt_target_mv
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic sel_meta;
    logic sel_sync;
    logic [7:0] rdata;
    logic [NUM_CONV-1:0] written;
    logic [NUM_CONV-1:0] sleep_active;
    logic [NUM_CONV-1:0][6:0] code;
    logic [NUM_CONV-1:0][11:0] target_mv;
  } bank_state_t;

  bank_state_t state_ff;
  bank_state_t nxt_state;

  // ****************************************************
  // per-converter decode, storage and scaling
  // ****************************************************
  logic [NUM_CONV-1:0] hit;
  logic [NUM_CONV-1:0] reg_wr_en;
  logic [NUM_CONV-1:0][7:0] reg_value;
  logic [NUM_CONV-1:0][11:0] scaled_mv;
  buck_alt_pkg::buck_mode_t [NUM_CONV-1:0] alt_mode;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CONV; gi++) begin : g_conv
      assign hit[gi] = (addr == buck_alt_pkg::CONV_OFFSET[gi]);
      // writes only land while the clock enable is high
      assign reg_wr_en[gi] = clock_en & wr & hit[gi];

      alt_setting_reg #(
        .RESET_VALUE(buck_alt_pkg::ALT_SETTING_RESET)
      ) u_reg (
        .clock(clock),
        .rstn(rstn),
        .wr_en(reg_wr_en[gi]),
        .wdata(wdata),
        .value(reg_value[gi])
      );

      alt_voltage_scale #(
        .BASE_MV(buck_alt_pkg::CONV_BASE_MV[gi]),
        .STEP_MV(buck_alt_pkg::CONV_STEP_MV[gi])
      ) u_scale (
        .code(reg_value[gi][buck_alt_pkg::CODE_MSB:buck_alt_pkg::CODE_LSB]),
        .millivolts(scaled_mv[gi])
      );

      // bit 7 picks the mode only while the alternate set is in use
      assign alt_mode[gi] = buck_alt_pkg::buck_mode_t'(reg_value[gi][buck_alt_pkg::SLEEP_BIT]);
    end
  endgenerate

  // ****************************************************
  // read mux
  // ****************************************************
  logic [7:0] read_value;
  logic [7:0] status_value;

  always_comb begin
    status_value = 8'h00;
    status_value[buck_alt_pkg::STATUS_SEL_BIT] = state_ff.sel_sync;
    status_value[buck_alt_pkg::STATUS_WRITTEN_LSB +: NUM_CONV] = state_ff.written;
  end

  // unmapped offsets read as zero; reading never disturbs any state
  always_comb begin
    read_value = buck_alt_pkg::READ_IDLE_VALUE;
    for (int i = 0; i < NUM_CONV; i++) begin
      if (hit[i]) begin
        read_value = reg_value[i];
      end
    end
    if (addr == buck_alt_pkg::ALT_STATUS_OFFSET) begin
      read_value = status_value;
    end
  end

  // ****************************************************
  // next state
  // ****************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_state.sel_meta = alt_select_pin;
    nxt_state.sel_sync = state_ff.sel_meta;
    // read data stands in the cycle after the strobe only
    if (rd) begin
      nxt_state.rdata = read_value;
    end else begin
      nxt_state.rdata = buck_alt_pkg::READ_IDLE_VALUE;
    end
    nxt_state.written = state_ff.written | reg_wr_en;
    for (int i = 0; i < NUM_CONV; i++) begin
      nxt_state.sleep_active[i] = state_ff.sel_sync & (alt_mode[i] == buck_alt_pkg::MODE_SLEEP);
      nxt_state.code[i] = reg_value[i][buck_alt_pkg::CODE_MSB:buck_alt_pkg::CODE_LSB];
      nxt_state.target_mv[i] = scaled_mv[i];
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '0;
    end else if (clock_en) begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign rdata = state_ff.rdata;
  assign alt_selected = state_ff.sel_sync;

  assign first_core_alt_sleep_active = state_ff.sleep_active[0];
  assign first_core_alt_voltage_code = state_ff.code[0];
  assign first_core_alt_target_mv = state_ff.target_mv[0];

  assign second_core_alt_sleep_active = state_ff.sleep_active[1];
  assign second_core_alt_voltage_code = state_ff.code[1];
  assign second_core_alt_target_mv = state_ff.target_mv[1];

  assign processor_alt_sleep_active = state_ff.sleep_active[2];
  assign processor_alt_voltage_code = state_ff.code[2];
  assign processor_alt_target_mv = state_ff.target_mv[2];

  assign memory_alt_sleep_active = state_ff.sleep_active[3];
  assign memory_alt_voltage_code = state_ff.code[3];
  assign memory_alt_target_mv = state_ff.target_mv[3];

  assign io_alt_sleep_active = state_ff.sleep_active[4];
  assign io_alt_voltage_code = state_ff.code[4];
  assign io_alt_target_mv = state_ff.target_mv[4];

endmodule // buck_alt_voltage_regs

// ### verif/buck_alt_voltage_regs_properties.sv
// assertions on the ports of the alternate buck setting bank
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module buck_alt_voltage_regs_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic alt_selected,
  input wire logic processor_alt_sleep_active,
  input wire logic [6:0] first_core_alt_voltage_code,
  input wire logic [11:0] first_core_alt_target_mv,
  input wire logic [6:0] second_core_alt_voltage_code,
  input wire logic [6:0] processor_alt_voltage_code,
  input wire logic [11:0] processor_alt_target_mv,
  input wire logic [6:0] memory_alt_voltage_code,
  input wire logic [11:0] memory_alt_target_mv,
  input wire logic [6:0] io_alt_voltage_code,
  input wire logic [11:0] io_alt_target_mv
);
  // ****************************************************
  // properties
  // ****************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (clock_en && !rd |=> rdata == 8'h00)
    else $error("read data not idle");
  a_write_then_read: assert property (clock_en && wr && addr == 8'hB7 ##1 clock_en && rd && addr == 8'hB7
    |=> rdata == $past(wdata, 2)) else $error("readback differs from write");
  a_core_two_code: assert property (clock_en && wr && addr == 8'hB5 ##1 clock_en
    |=> second_core_alt_voltage_code == $past(wdata[6:0], 2)) else $error("second core code stale");
  a_core_one_scale: assert property ($past(rstn) && $past(clock_en)
    |-> first_core_alt_target_mv == 12'h12C + 12'(first_core_alt_voltage_code) * 12'h00A) else $error("core scale");
  a_processor_scale: assert property ($past(rstn) && $past(clock_en)
    |-> processor_alt_target_mv == 12'h212 + 12'(processor_alt_voltage_code) * 12'h00A) else $error("cpu scale");
  a_memory_scale: assert property ($past(rstn) && $past(clock_en)
    |-> memory_alt_target_mv == 12'h320 + 12'(memory_alt_voltage_code) * 12'h014) else $error("memory scale");
  a_io_scale: assert property ($past(rstn) && $past(clock_en)
    |-> io_alt_target_mv == 12'h320 + 12'(io_alt_voltage_code) * 12'h014) else $error("io scale");
  a_sleep_needs_alt: assert property ($past(rstn) && $past(clock_en) && processor_alt_sleep_active
    |-> $past(alt_selected)) else $error("sleep without alternate set");
  c_write: cover property (clock_en && wr && addr == 8'hB5);
  c_read: cover property (clock_en && rd && addr == 8'hB7);
  c_sleep: cover property (processor_alt_sleep_active);
endmodule // buck_alt_voltage_regs_properties

bind buck_alt_voltage_regs buck_alt_voltage_regs_properties buck_alt_voltage_regs_properties_i (.clock(clock),
  .rstn(rstn), .clock_en(clock_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .alt_selected(alt_selected), .processor_alt_sleep_active(processor_alt_sleep_active),
  .first_core_alt_voltage_code(first_core_alt_voltage_code), .first_core_alt_target_mv(first_core_alt_target_mv),
  .second_core_alt_voltage_code(second_core_alt_voltage_code),
  .processor_alt_voltage_code(processor_alt_voltage_code), .processor_alt_target_mv(processor_alt_target_mv),
  .memory_alt_voltage_code(memory_alt_voltage_code), .memory_alt_target_mv(memory_alt_target_mv),
  .io_alt_voltage_code(io_alt_voltage_code), .io_alt_target_mv(io_alt_target_mv));

// ### verif/buck_alt_voltage_regs_tb.sv
// self-checking bench for the alternate buck setting bank
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module buck_alt_voltage_regs_tb;
  logic clock, rstn, clock_en, wr, rd, alt_select_pin, alt_selected;
  logic [7:0] addr, wdata, rdata, rv;
  logic [4:0] sl;
  logic [6:0] cd [5];
  logic [11:0] mv [5];
  int n_errors, compares, cycles;
  // values written per converter and the target each must show
  logic [7:0] wv [5] = '{8'hFF, 8'h75, 8'hFF, 8'h14, 8'hBD};
  logic [11:0] top_mv [5] = '{12'h622, 12'h5BE, 12'h708, 12'h4B0, 12'h7E4};
  logic [11:0] base_mv [5] = '{12'h12C, 12'h12C, 12'h212, 12'h320, 12'h320};

  buck_alt_voltage_regs buck_alt_voltage_regs_i (.clock(clock), .rstn(rstn), .clock_en(clock_en), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alt_select_pin(alt_select_pin), .alt_selected(alt_selected),
    .first_core_alt_sleep_active(sl[0]), .first_core_alt_voltage_code(cd[0]), .first_core_alt_target_mv(mv[0]),
    .second_core_alt_sleep_active(sl[1]), .second_core_alt_voltage_code(cd[1]), .second_core_alt_target_mv(mv[1]),
    .processor_alt_sleep_active(sl[2]), .processor_alt_voltage_code(cd[2]), .processor_alt_target_mv(mv[2]),
    .memory_alt_sleep_active(sl[3]), .memory_alt_voltage_code(cd[3]), .memory_alt_target_mv(mv[3]),
    .io_alt_sleep_active(sl[4]), .io_alt_voltage_code(cd[4]), .io_alt_target_mv(mv[4]));

  // ****************************************************
  // bus tasks and comparison
  // ****************************************************
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
    @(posedge clock);
    #1;
    check(12'(rdata), 12'h000);
  endtask
  task automatic summarize;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset_values;
    for (int i = 0; i < 5; i++) begin
      rd_reg(8'hB4 + 8'(i));
      check(12'(rv), 12'h000);
      check(mv[i], base_mv[i]);
    end
  endtask
  task automatic t_fields;
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'hB4 + 8'(i), wv[i]);
      repeat (2) @(posedge clock);
      #1;
      check(12'(cd[i]), 12'(wv[i][6:0]));
      check(mv[i], top_mv[i]);
      check(12'(sl[i]), 12'h000);
      rd_reg(8'hB4 + 8'(i));
      check(12'(rv), 12'(wv[i]));
    end
  endtask
  task automatic t_sleep;
    @(posedge clock);
    alt_select_pin <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check(12'(sl), 12'h015);
    check(12'(alt_selected), 12'h001);
    rd_reg(8'hF0);
    check(12'(rv), 12'h03F);
    @(posedge clock);
    alt_select_pin <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check(12'(sl), 12'h000);
    check(12'(alt_selected), 12'h000);
  endtask
  task automatic t_refused_and_back_to_back;
    @(posedge clock);
    clock_en <= 1'b0;
    wr_reg(8'hB6, 8'h00);
    clock_en <= 1'b1;
    rd_reg(8'hB6);
    check(12'(rv), 12'h0FF);
    wr_reg(8'hB9, 8'h55);
    rd_reg(8'hB9);
    check(12'(rv), 12'h000);
    wr_reg(8'hF0, 8'h00);
    rd_reg(8'hF0);
    check(12'(rv), 12'h03E);
    @(posedge clock);
    wr <= 1'b1;
    addr <= 8'hB7;
    wdata <= 8'h7F;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(12'(rdata), 12'h07F);
    repeat (2) @(posedge clock);
    #1;
    check(mv[3], 12'hD0C);
  endtask
  // reset in mid-run clears the registers and the written flags
  task automatic t_mid_reset;
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    rd_reg(8'hF0);
    check(12'(rv), 12'h000);
    rd_reg(8'hB7);
    check(12'(rv), 12'h000);
    check(mv[3], 12'h320);
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    rstn = 1'b0;
    clock_en = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    alt_select_pin = 1'b0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_reset_values();
    t_fields();
    t_sleep();
    t_refused_and_back_to_back();
    t_mid_reset();
    summarize();
  end
endmodule // buck_alt_voltage_regs_tb
